// [rtl/adc_link_pkg.sv]
// constants shared by the converter serial-link controller
package adc_link_pkg;
  // clock and link timing
  localparam int CLK_NS        = 20;
  localparam int CLK_KHZ       = 50000;
  localparam int SCK_KHZ       = 4190;
  localparam int SCK_HALF_CYC  = (CLK_KHZ + 2 * SCK_KHZ - 1) / (2 * SCK_KHZ);
  localparam int DELAY_NS      = 19000;
  localparam int DELAY_CYC     = (DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_LAT      = 2;
  localparam int RESULT_BITS   = 16;
  localparam int START_BITS    = 8;
  localparam int DLY_W         = 16;
  localparam int DIV_W         = 8;
  localparam int CNT_W         = 5;

  // register offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_DELAY  = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_RESULT = 8'h0C;

  // field positions
  localparam int CTRL_RUN    = 0;
  localparam int CTRL_MODE   = 1;
  localparam int STAT_NEW    = 0;
  localparam int STAT_OVR    = 1;
  localparam int STAT_ARMED  = 2;
  localparam int STAT_ACTIVE = 3;

  // reset values
  localparam logic [DLY_W-1:0] DELAY_RST = DLY_W'(DELAY_CYC);
  localparam logic             RUN_RST   = 1'b0;
  localparam logic             MODE_RST  = 1'b0;

  // queue command bytes and their fields
  localparam logic [7:0] CMD_START = 8'h20;
  localparam logic [7:0] CMD_READ  = 8'h61;
  localparam int         CMD_BITSE = 6;
  localparam int         CMD_DT    = 5;
  localparam int         CMD_SELECT_TO_CLOCK_DELAY  = 4;
endpackage

// [rtl/rx_word_if.sv]
// carries a received word from the link domain to the host domain
`timescale 1ns/100ps
interface rx_word_if;
  logic [adc_link_pkg::RESULT_BITS-1:0] word;
  logic                                 full;
  modport link (output word, output full);
  modport host (input word, input full);
endinterface

// [rtl/bit_sync.sv]
// two-flop synchroniser for a group of independent levels
`timescale 1ns/100ps
module bit_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_q;

  always_comb begin
    nxt_meta = rst_n ? d : '0;
    nxt_q    = rst_n ? meta_ff : '0;
  end

  always_ff @(posedge clk) begin
    meta_ff <= nxt_meta;
    q_ff    <= nxt_q;
  end

  assign q = q_ff;
endmodule

// [rtl/link_rx.sv]
// shift receiver clocked by the converter's serial clock
`timescale 1ns/100ps
module link_rx (
  // link pins
  input  wire logic link_sck,
  input  wire logic sel_idle,
  input  wire logic serial_in,
  // word to host domain
  rx_word_if.link   rx
);
  localparam int B = adc_link_pkg::RESULT_BITS;

  logic [B-1:0]                   sh_ff;
  logic [adc_link_pkg::CNT_W-1:0] cnt_ff;
  logic                           full_ff;
  logic [B-1:0]                   nxt_sh;
  logic [adc_link_pkg::CNT_W-1:0] nxt_cnt;
  logic                           nxt_full;

  // bits taken on the falling edge, msb first; frame stops at a full word
  always_comb begin
    nxt_sh   = sh_ff;
    nxt_cnt  = cnt_ff;
    nxt_full = full_ff;
    if (!full_ff) begin
      nxt_sh  = {sh_ff[B-2:0], serial_in}; // R1 R14
      nxt_cnt = cnt_ff + 1'b1;
      if (cnt_ff == adc_link_pkg::CNT_W'(B - 1)) begin
        nxt_full = 1'b1;
      end
    end
  end

  // select high between frames clears the count; the clock may stand still
  always_ff @(negedge link_sck or posedge sel_idle) begin
    if (sel_idle) begin
      sh_ff   <= '0;
      cnt_ff  <= '0;
      full_ff <= 1'b0;
    end else begin
      sh_ff   <= nxt_sh;
      cnt_ff  <= nxt_cnt;
      full_ff <= nxt_full;
    end
  end

  assign rx.word = sh_ff;
  assign rx.full = full_ff;
endmodule

// [rtl/adc_link_host.sv]
// host controller for the sampling converter's serial link
//
// Functional notes
// R1 - converter-clocked scheme: host listens as slave, idle-low clock, falling edge
// R2 - host arms its receiver only after the select line falls
// R3 - start transfer is 8 bits with both selects low
// R4 - read transfer is 16 bits with only chip select low
// R5 - a 19 us delay follows each of the two transfers
// R6 - queue wraps to its first entry after the read transfer
// R7 - data taken from tristatable msb pin; selects high when idle
// R8 - fastest clock, no select-to-clock delay; longer delay gives slower rate
// R9 - the serial clock is never slowed below its fixed rate
// R10 - host-driven clock idles low, data captured at rising edge
// R11 - command bytes are 20h for start and 61h for read
// R12 - whole result kept before the next bits can overwrite it
// R13 - converter inputs stay static until busy rises again
// R14 - result arrives msb first and is assembled in that order
`timescale 1ns/100ps
module adc_link_host (
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  // register port
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  // converter-clocked link
  input  wire logic        LINK_SCK,
  input  wire logic        SERIAL_RESULT_OUT,
  input  wire logic        ADC_BUSY,
  // host-clocked link
  input  wire logic        PARALLEL_MSB_OUT,
  output logic             HOST_SCK,
  output logic             HOST_SELECT_ZERO,
  output logic             HOST_SELECT_ONE
);
  localparam int B    = adc_link_pkg::RESULT_BITS;
  localparam int DW   = adc_link_pkg::DLY_W;
  localparam int VW   = adc_link_pkg::DIV_W;
  localparam int CW   = adc_link_pkg::CNT_W;
  localparam logic [VW-1:0] HALF  = VW'(adc_link_pkg::SCK_HALF_CYC);
  localparam logic [VW-1:0] SAMP  = VW'(adc_link_pkg::SYNC_LAT);
  localparam logic [CW-1:0] NB16  = CW'(adc_link_pkg::RESULT_BITS);
  localparam logic [CW-1:0] NB8   = CW'(adc_link_pkg::START_BITS);

  typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_GAP, ST_WAIT} eng_e;

  // queue of command bytes
  logic [7:0] queue [2];
  assign queue[0] = adc_link_pkg::CMD_START; // R3 R11
  assign queue[1] = adc_link_pkg::CMD_READ;  // R4 R11

  // synchronised pins and the link word
  rx_word_if rx ();
  logic [2:0] sync_q;
  logic       busy_s;
  logic       msb_s;
  logic       full_s;

  link_rx u_rx (
    .link_sck  (LINK_SCK),
    .sel_idle  (ADC_BUSY),
    .serial_in (SERIAL_RESULT_OUT),
    .rx        (rx.link)
  );

  bit_sync #(.W(3)) u_sync (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .d     ({rx.full, PARALLEL_MSB_OUT, ADC_BUSY}),
    .q     (sync_q)
  );
  assign busy_s = sync_q[0];
  assign msb_s  = sync_q[1];
  assign full_s = sync_q[2];

  // register state
  logic          run_ff, mode_ff, new_ff, ovr_ff, armed_ff;
  logic          busy_d_ff, full_d_ff;
  logic [DW-1:0] delay_ff;
  logic [B-1:0]  result_ff;
  logic [31:0]   rdata_ff;
  logic          nxt_run, nxt_mode, nxt_new, nxt_ovr, nxt_armed;
  logic          nxt_busy_d, nxt_full_d;
  logic [DW-1:0] nxt_delay;
  logic [B-1:0]  nxt_result;
  logic [31:0]   nxt_rdata;

  // engine state
  eng_e          st_ff, nxt_st;
  logic          entry_ff, nxt_entry;
  logic [CW-1:0] bit_ff, nxt_bit;
  logic [VW-1:0] div_ff, nxt_div;
  logic [DW-1:0] gap_ff, nxt_gap;
  logic          lead_ff, nxt_lead;
  logic          sck_ff, nxt_sck;
  logic [1:0]    sel_ff, nxt_sel;
  logic [B-1:0]  sh_ff, nxt_sh;
  logic          done_pulse;
  logic [7:0]    cmd;
  logic [CW-1:0] nbits;

  assign cmd   = queue[entry_ff];
  assign nbits = cmd[adc_link_pkg::CMD_BITSE] ? NB16 : NB8;

  // host-driven transfer engine
  always_comb begin
    nxt_st     = st_ff;
    nxt_entry  = entry_ff;
    nxt_bit    = bit_ff;
    nxt_div    = div_ff;
    nxt_gap    = gap_ff;
    nxt_lead   = lead_ff;
    nxt_sck    = sck_ff;
    nxt_sel    = sel_ff;
    nxt_sh     = sh_ff;
    done_pulse = 1'b0;
    case (st_ff)
      ST_IDLE: begin
        nxt_sel = 2'b11; // R7
        nxt_sck = 1'b0;  // R10
        if (run_ff && mode_ff) begin
          nxt_entry = 1'b0;
          nxt_st    = ST_XFER;
          nxt_bit   = '0;
          nxt_div   = '0;
          nxt_sel   = queue[0][1:0]; // R3
          nxt_lead  = queue[0][adc_link_pkg::CMD_SELECT_TO_CLOCK_DELAY]; // R8
        end
      end
      ST_XFER: begin
        nxt_div = div_ff + 1'b1;
        if (lead_ff) begin
          if (div_ff == HALF - 1'b1) begin
            nxt_lead = 1'b0;
            nxt_div  = '0;
          end
        end else if (div_ff == HALF - 1'b1) begin
          // fixed divider: the clock rate cannot be lowered
          nxt_div = '0; // R9
          nxt_sck = ~sck_ff;
          if (sck_ff) begin
            nxt_bit = bit_ff + 1'b1;
            if (bit_ff == nbits - 1'b1) begin
              nxt_sel = 2'b11; // R7
              nxt_gap = '0;
              if (cmd[adc_link_pkg::CMD_BITSE]) begin
                done_pulse = 1'b1; // R12
              end
              nxt_st = cmd[adc_link_pkg::CMD_DT] ? ST_GAP : ST_WAIT;
            end
          end
        end else if (sck_ff && div_ff == SAMP) begin
          // pin seen through the synchroniser, taken after the rise
          nxt_sh = {sh_ff[B-2:0], msb_s}; // R4 R7 R10 R14
        end
      end
      ST_GAP: begin
        nxt_gap = gap_ff + 1'b1;
        if (gap_ff >= delay_ff - 1'b1) begin // R5
          nxt_st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // next entry, wrapping after the read; read waits for busy high
        if (!run_ff || !mode_ff) begin
          nxt_st = ST_IDLE;
        end else if (entry_ff || busy_s) begin // R6 R13
          nxt_entry = ~entry_ff;
          nxt_st    = ST_XFER;
          nxt_bit   = '0;
          nxt_div   = '0;
          nxt_sh    = '0;
          nxt_sel   = queue[~entry_ff][1:0]; // R3 R4
          nxt_lead  = queue[~entry_ff][adc_link_pkg::CMD_SELECT_TO_CLOCK_DELAY]; // R8
        end
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      st_ff    <= ST_IDLE;
      entry_ff <= 1'b0;
      bit_ff   <= '0;
      div_ff   <= '0;
      gap_ff   <= '0;
      lead_ff  <= 1'b0;
      sck_ff   <= 1'b0;
      sel_ff   <= 2'b11;
      sh_ff    <= '0;
    end else begin
      st_ff    <= nxt_st;
      entry_ff <= nxt_entry;
      bit_ff   <= nxt_bit;
      div_ff   <= nxt_div;
      gap_ff   <= nxt_gap;
      lead_ff  <= nxt_lead;
      sck_ff   <= nxt_sck;
      sel_ff   <= nxt_sel;
      sh_ff    <= nxt_sh;
    end
  end

  // registers, listen-mode arming and result capture
  logic slave_take;
  logic take;
  logic [B-1:0] take_word;

  always_comb begin
    nxt_run    = run_ff;
    nxt_mode   = mode_ff;
    nxt_delay  = delay_ff;
    nxt_armed  = armed_ff;
    nxt_new    = new_ff;
    nxt_ovr    = ovr_ff;
    nxt_result = result_ff;
    nxt_busy_d = busy_s;
    nxt_full_d = full_s;
    nxt_rdata  = 32'h0000_0000;
    slave_take = 1'b0;
    // arm only on a falling select seen while listening
    if (run_ff && !mode_ff && busy_d_ff && !busy_s) begin
      nxt_armed = 1'b1; // R2
    end
    if (full_s && !full_d_ff) begin
      slave_take = armed_ff; // R1 R2
      nxt_armed  = 1'b0;
    end
    take      = slave_take || done_pulse;
    take_word = done_pulse ? sh_ff : rx.word;
    if (REG_RD) begin
      case (REG_ADDR)
        adc_link_pkg::OFF_CTRL: begin
          nxt_rdata[adc_link_pkg::CTRL_RUN]  = run_ff;
          nxt_rdata[adc_link_pkg::CTRL_MODE] = mode_ff;
        end
        adc_link_pkg::OFF_DELAY: begin
          nxt_rdata[DW-1:0] = delay_ff;
        end
        adc_link_pkg::OFF_STATUS: begin
          nxt_rdata[adc_link_pkg::STAT_NEW]    = new_ff;
          nxt_rdata[adc_link_pkg::STAT_OVR]    = ovr_ff;
          nxt_rdata[adc_link_pkg::STAT_ARMED]  = armed_ff;
          nxt_rdata[adc_link_pkg::STAT_ACTIVE] = (st_ff != ST_IDLE);
        end
        adc_link_pkg::OFF_RESULT: begin
          nxt_rdata[B-1:0] = result_ff;
          nxt_new          = 1'b0;
        end
        default: begin
          nxt_rdata = 32'h0000_0000;
        end
      endcase
    end
    if (REG_WR) begin
      case (REG_ADDR)
        adc_link_pkg::OFF_CTRL: begin
          nxt_run  = REG_WDATA[adc_link_pkg::CTRL_RUN];
          nxt_mode = REG_WDATA[adc_link_pkg::CTRL_MODE];
          if (!REG_WDATA[adc_link_pkg::CTRL_RUN]) begin
            nxt_armed = 1'b0;
          end
        end
        adc_link_pkg::OFF_DELAY: begin
          // shorter than the documented delay is raised to it
          if (REG_WDATA[DW-1:0] < adc_link_pkg::DELAY_RST) begin
            nxt_delay = adc_link_pkg::DELAY_RST; // R5 R8
          end else begin
            nxt_delay = REG_WDATA[DW-1:0]; // R8
          end
        end
        adc_link_pkg::OFF_STATUS: begin
          if (REG_WDATA[adc_link_pkg::STAT_OVR]) begin
            nxt_ovr = 1'b0;
          end
        end
        default: begin
          nxt_ovr = nxt_ovr;
        end
      endcase
    end
    // a new word wins over a clear in the same cycle
    if (take) begin
      nxt_result = take_word; // R12 R14
      nxt_ovr    = nxt_ovr | new_ff;
      nxt_new    = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      run_ff    <= adc_link_pkg::RUN_RST;
      mode_ff   <= adc_link_pkg::MODE_RST;
      delay_ff  <= adc_link_pkg::DELAY_RST;
      armed_ff  <= 1'b0;
      new_ff    <= 1'b0;
      ovr_ff    <= 1'b0;
      result_ff <= '0;
      busy_d_ff <= 1'b0;
      full_d_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
    end else begin
      run_ff    <= nxt_run;
      mode_ff   <= nxt_mode;
      delay_ff  <= nxt_delay;
      armed_ff  <= nxt_armed;
      new_ff    <= nxt_new;
      ovr_ff    <= nxt_ovr;
      result_ff <= nxt_result;
      busy_d_ff <= nxt_busy_d;
      full_d_ff <= nxt_full_d;
      rdata_ff  <= nxt_rdata;
    end
  end

  assign REG_RDATA        = rdata_ff;
  assign HOST_SCK         = sck_ff;
  assign HOST_SELECT_ZERO = sel_ff[0];
  assign HOST_SELECT_ONE  = sel_ff[1];
endmodule

// [sim/adc_link_host_sva.sv]
// concurrent checks on the controller's host-driven link pins
`timescale 1ns/100ps
module adc_link_host_sva (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // link pins
  input wire logic ADC_BUSY,
  input wire logic HOST_SCK,
  input wire logic HOST_SELECT_ZERO,
  input wire logic HOST_SELECT_ONE
);
  logic [15:0] gap_ff;
  logic [15:0] nxt_gap;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  // cycles the chip select has stayed high, saturating
  always_comb begin
    nxt_gap = gap_ff;
    if (!HOST_SELECT_ONE) begin
      nxt_gap = 16'h0000;
    end else if (gap_ff != 16'hFFFF) begin
      nxt_gap = gap_ff + 16'h0001;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      gap_ff <= 16'hFFFF;
    end else begin
      gap_ff <= nxt_gap;
    end
  end

  a_sck_idle_low: assert property (HOST_SELECT_ONE |-> !HOST_SCK)
    else $error("serial clock moves while deselected");
  a_trigger_needs_cs: assert property (!HOST_SELECT_ZERO |-> !HOST_SELECT_ONE)
    else $error("convert trigger low without chip select");
  a_sck_high_half: assert property ($rose(HOST_SCK) |->
    HOST_SCK [*6] ##1 !HOST_SCK)
    else $error("serial clock high half period wrong");
  a_sck_low_half: assert property ($fell(HOST_SCK) && !HOST_SELECT_ONE |->
    !HOST_SCK [*6] ##1 HOST_SCK)
    else $error("serial clock low half period wrong");
  a_no_lead_delay: assert property ($fell(HOST_SELECT_ONE) |->
    !HOST_SCK [*6] ##1 HOST_SCK)
    else $error("first clock edge not one half period after select");
  a_start_length: assert property ($fell(HOST_SELECT_ZERO) |->
    ##95 !HOST_SELECT_ZERO ##1 (HOST_SELECT_ZERO && HOST_SELECT_ONE))
    else $error("start transfer is not eight clocks long");
  a_read_length: assert property ($fell(HOST_SELECT_ONE) && HOST_SELECT_ZERO
    |-> ##191 !HOST_SELECT_ONE ##1 HOST_SELECT_ONE)
    else $error("read transfer is not sixteen clocks long");
  a_gap_minimum: assert property ($fell(HOST_SELECT_ONE) |->
    gap_ff >= 16'h03B6)
    else $error("post-transfer delay too short");
  a_read_after_busy: assert property ($fell(HOST_SELECT_ONE) &&
    HOST_SELECT_ZERO |-> $past(ADC_BUSY, 3))
    else $error("read started while converter busy");
endmodule

bind adc_link_host adc_link_host_sva adc_link_host_sva_inst (
  .REF_CLK          (REF_CLK),
  .RST_N            (RST_N),
  .ADC_BUSY         (ADC_BUSY),
  .HOST_SCK         (HOST_SCK),
  .HOST_SELECT_ZERO (HOST_SELECT_ZERO),
  .HOST_SELECT_ONE  (HOST_SELECT_ONE)
);

// [sim/adc_conversion_trigger_n_model.sv]
// behavioural model of the sampling converter at the link pins
`timescale 1ns/100ps
module adc_conversion_trigger_n_model #(
  parameter int CONVERSION_TRIGGER_N_NS = 12000
) (
  // host-driven pins
  input  wire logic        host_sck,
  input  wire logic        sel_zero_n,
  input  wire logic        sel_one_n,
  // converter outputs
  output logic             busy,
  output logic             msb_out,
  output logic             link_sck,
  output logic             serial_out,
  // test control
  input  wire logic [15:0] sample,
  input  wire logic        listen_go
);
  logic [15:0] result;
  logic [15:0] shift;

  initial begin
    busy       = 1'b1;
    msb_out    = 1'b1;
    link_sck   = 1'b0;
    serial_out = 1'b0;
    result     = 16'h0000;
    shift      = 16'h0000;
  end

  // conversion runs after the start transfer; busy rises when done
  always @(negedge sel_zero_n) begin
    @(posedge sel_zero_n);
    busy = 1'b0;
    #(CONVERSION_TRIGGER_N_NS);
    result = sample;
    busy   = 1'b1;
  end

  // result leaves on the msb pin, msb first, next bit after each fall
  always @(negedge sel_one_n) begin
    if (sel_zero_n) begin
      shift   = result;
      msb_out = shift[15];
    end
  end

  always @(negedge host_sck) begin
    if (!sel_one_n && sel_zero_n) begin
      shift   = {shift[14:0], 1'b0};
      msb_out = shift[15];
    end
  end

  // released pin floats: show the inverse of the last bit
  always @(posedge sel_one_n) begin
    msb_out = ~msb_out;
  end

  // self-clocked frame: clock idles low, data valid at falling edge
  always @(posedge listen_go) begin
    busy = 1'b0;
    #500;
    for (int i = 15; i >= 0; i--) begin
      link_sck   = 1'b1;
      serial_out = sample[i];
      #62.5 link_sck = 1'b0;
      #62.5;
    end
    serial_out = ~serial_out;
    // word must stand until the host domain has taken it
    #1000;
    busy       = 1'b1;
  end
endmodule

// [sim/tb_top.sv]
// self-checking bench for the converter serial-link controller
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] exp;
  } row_s;
  localparam logic [7:0] A_CTRL = adc_link_pkg::OFF_CTRL;
  localparam logic [7:0] A_DLY  = adc_link_pkg::OFF_DELAY;
  localparam logic [7:0] A_STAT = adc_link_pkg::OFF_STATUS;
  localparam logic [7:0] A_RES  = adc_link_pkg::OFF_RESULT;
  logic        ref_clk;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        link_sck;
  logic        serial_out;
  logic        busy;
  logic        msb_out;
  logic        host_sck;
  logic        sel_zero_n;
  logic        sel_one_n;
  logic [15:0] sample;
  logic        listen_go;
  logic [31:0] rd_val;
  int          n_fail;
  int          cmp_count;
  row_s        rows [5];
  logic [15:0] seq [3];

  adc_link_host adc_link_host_inst (
    .REF_CLK(ref_clk), .RST_N(rst_n), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .LINK_SCK(link_sck),
    .SERIAL_RESULT_OUT(serial_out), .ADC_BUSY(busy),
    .PARALLEL_MSB_OUT(msb_out), .HOST_SCK(host_sck),
    .HOST_SELECT_ZERO(sel_zero_n), .HOST_SELECT_ONE(sel_one_n));

  adc_conversion_trigger_n_model adc_conversion_trigger_n_model_inst (
    .host_sck(host_sck), .sel_zero_n(sel_zero_n), .sel_one_n(sel_one_n),
    .busy(busy), .msb_out(msb_out), .link_sck(link_sck),
    .serial_out(serial_out), .sample(sample), .listen_go(listen_go));

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  // poll for a fresh result, then fetch it
  task automatic wait_new();
    int i;
    i = 0;
    rd(A_STAT);
    while (rd_val[adc_link_pkg::STAT_NEW] !== 1'b1 && i < 3000) begin
      rd(A_STAT);
      i++;
    end
    chk("new flag", 32'(rd_val[adc_link_pkg::STAT_NEW]), 32'h1);
    rd(A_RES);
  endtask

  task automatic results();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    #1200000;
    n_fail++;
    results();
  end

  initial begin
    int i;
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sample = 16'h1234;
    listen_go = 1'b0;
    n_fail = 0;
    cmp_count = 0;
    rows = '{'{A_CTRL, 32'h0}, '{A_DLY, 32'h000003B6}, '{A_STAT, 32'h0},
             '{A_RES, 32'h0}, '{8'h10, 32'h0}};
    seq = '{16'hA5C3, 16'h5A3C, 16'hFFFE};
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    wr(8'h10, 32'hFFFFFFFF);
    foreach (rows[k]) begin
      rd(rows[k].addr);
      chk("reset value", rd_val, rows[k].exp);
    end
    @(posedge ref_clk);
    #1 chk("rdata idle", reg_rdata, 32'h0);
    // short delays clamp to the minimum gap; longer ones are kept
    wr(A_DLY, 32'h5);
    rd(A_DLY);
    chk("delay clamp", rd_val, 32'h000003B6);
    wr(A_DLY, 32'h000003E8);
    rd(A_DLY);
    chk("delay long", rd_val, 32'h000003E8);
    wr(A_DLY, 32'h000003B6);
    // a frame before the listener is armed is dropped
    listen_go <= 1'b1;
    @(posedge ref_clk);
    listen_go <= 1'b0;
    // run is set after busy has fell, so this frame must not arm
    repeat (40) @(posedge ref_clk);
    wr(A_CTRL, 32'h1);
    sample <= 16'h8001;
    repeat (200) @(posedge ref_clk);
    rd(A_STAT);
    chk("unarmed frame", 32'(rd_val[adc_link_pkg::STAT_NEW]), 32'h0);
    listen_go <= 1'b1;
    @(posedge ref_clk);
    listen_go <= 1'b0;
    wait_new();
    chk("listen result", rd_val, 32'h00008001);
    // host queue: three samples through the wrapping queue
    sample <= seq[0];
    wr(A_CTRL, 32'h3);
    for (int k = 0; k < 3; k++) begin
      wait_new();
      chk("queue result", rd_val, {16'h0, seq[k]});
      sample <= seq[(k + 1) % 3];
    end
    // two unread results raise overrun; writing one clears it
    repeat (5000) @(posedge ref_clk);
    rd(A_STAT);
    chk("overrun set", rd_val, 32'h0000000B);
    wr(A_STAT, 32'h2);
    rd(A_STAT);
    chk("overrun clear", rd_val, 32'h00000009);
    // reset in mid-transfer returns the pins to idle
    i = 0;
    while (sel_one_n !== 1'b0 && i < 3000) begin
      @(posedge ref_clk);
      i++;
    end
    rst_n <= 1'b0;
    repeat (16) @(posedge ref_clk);
    chk("trigger idle", 32'(sel_zero_n), 32'h1);
    chk("select idle", 32'(sel_one_n), 32'h1);
    chk("clock idle", 32'(host_sck), 32'h0);
    rst_n <= 1'b1;
    rd(A_CTRL);
    chk("ctrl after reset", rd_val, 32'h0);
    results();
  end
endmodule
